// ---- hdl/ccl_comparator_ctrl.sv ----
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// [RULE1] Mux-select on and converter off routes converter mux to negative input.
// [RULE2] Mux-select off connects the negative pin to the negative input.
// [RULE3] Power-off bit removes comparator power; writable at any time.
// [RULE4] Software clears irq enable before changing the power-off bit.
// [RULE5] Bandgap-select feeds bandgap to positive input, else positive pin.
// [RULE6] Raw output synchronised into status bit with one to two cycle delay.
// [RULE7] Event flag sets on the edge type chosen by event mode.
// [RULE8] Interrupt request only with flag, enable and global enable all set.
// [RULE9] Flag clears when vector taken, or when software writes one.
// [RULE10] Capture-route bit drives comparator output to timer capture front end.
// [RULE11] Event mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
// [RULE12] Software clears irq enable before changing event mode.
// [RULE13] Pin buffer-off bit forces that pin's port input reading to zero.
// [RULE14] Control B: bit 6 read/write, bits 7,5,4 read zero, reset zero.
// [RULE15] Channel select low bits pick converter inputs 0 to 7 as negative.
// [RULE16] Output is high when positive input exceeds negative input.
// [RULE17] Edge detection compares current synchronised output with prior cycle.
// [RULE18] Reserved event mode never sets the event flag.
// [RULE19] Powered off: synchronised output held zero, no flag events.
module ccl_comparator_ctrl
	import ccl_pkg::*;
(
	input  wire logic                  clk,              // System clock
	input  wire logic                  rst,              // Async reset
	// AXI4-Lite write address
	input  wire logic [ccl_pkg::CCL_AW-1:0] s_axi_awaddr,  // Write address
	input  wire logic                  s_axi_awvalid,    // Address valid
	output logic                       s_axi_awready,    // Address ready
	// AXI4-Lite write data
	input  wire logic [31:0]           s_axi_wdata,      // Write data
	input  wire logic [3:0]            s_axi_wstrb,      // Byte strobes
	input  wire logic                  s_axi_wvalid,     // Data valid
	output logic                       s_axi_wready,     // Data ready
	// AXI4-Lite write response
	output logic [1:0]                 s_axi_bresp,      // Write response
	output logic                       s_axi_bvalid,     // Response valid
	input  wire logic                  s_axi_bready,     // Response ready
	// AXI4-Lite read
	input  wire logic [ccl_pkg::CCL_AW-1:0] s_axi_araddr,  // Read address
	input  wire logic                  s_axi_arvalid,    // Address valid
	output logic                       s_axi_arready,    // Address ready
	output logic [31:0]                s_axi_rdata,      // Read data
	output logic [1:0]                 s_axi_rresp,      // Read response
	output logic                       s_axi_rvalid,     // Read valid
	input  wire logic                  s_axi_rready,     // Read ready
	// Analog core and neighbours
	input  wire logic                  comp_raw_out,     // Raw comparator out
	input  wire logic                  cpu_global_irq_en,// Global enable
	input  wire logic                  irq_vector_taken, // Vector ack pulse
	input  wire logic                  comp_pos_pin_dig, // Pos pin digital
	input  wire logic                  comp_neg_pin_dig, // Neg pin digital
	input  wire logic [2:0]            neg_channel_select,// Converter mux sel
	output logic                       comp_power_off,   // Core power down
	output logic                       comp_bandgap_select,// Pos = bandgap
	output logic                       neg_mux_route,    // Neg = conv mux
	output logic [2:0]                 neg_channel_sel_out,// Neg mux channel
	output logic                       comp_irq,         // Interrupt request
	output logic                       capture_in,       // To timer capture
	output logic                       pos_pin_buffer_off,// Pos buffer off
	output logic                       neg_pin_buffer_off,// Neg buffer off
	output logic                       comp_pos_pin_read,// Port bit reading
	output logic                       comp_neg_pin_read // Port bit reading
);
	// Registers
	logic [7:0] ctrlB_ff;
	logic [7:0] csr_ff;
	logic [7:0] dis_ff;
	logic [3:0] conv_ff;
	logic       flag_ff;
	logic       irq_ff;
	logic       capture_ff;
	logic       powerOff_ff;
	logic       bgSel_ff;
	logic       negRoute_ff;
	logic [2:0] negChan_ff;
	logic       posRead_ff;
	logic       negRead_ff;
	logic       posPin1_ff;
	logic       posPin2_ff;
	logic       negPin1_ff;
	logic       negPin2_ff;
	// Bus state
	logic                awHeld_ff;
	logic                wHeld_ff;
	logic [CCL_AW-1:0]   awAddr_ff;
	logic [31:0]         wData_ff;
	logic [3:0]          wStrb_ff;
	logic                bValid_ff;
	logic [1:0]          bResp_ff;
	logic                rValid_ff;
	logic [31:0]         rData_ff;
	logic [1:0]          rResp_ff;
	// Internal
	logic       compSync;
	logic       compFire;
	logic       doWrite;
	logic       flagW1c;
	logic [7:0] wByte;
	logic       pwrOffNow;
	logic       bPending;

	assign pwrOffNow = csr_ff[CCL_S_PWROFF];
	// A response still waiting for the master keeps both readies low
	assign bPending  = bValid_ff & ~s_axi_bready;

	// [RULE6] two-flop sync
	// [RULE19] held low off
	ccl_sync u_sync (
		.clk   (clk),
		.rst   (rst),
		.clear (pwrOffNow),
		.din   (comp_raw_out),
		.dout  (compSync)
	);

	// [RULE7] edge selects event
	ccl_edge u_edge (
		.clk   (clk),
		.rst   (rst),
		.level (compSync),
		.mode  (csr_ff[1:0]),
		.block (pwrOffNow),
		.fire  (compFire)
	);

	// Write fires once both address and data are held and no reply is pending
	assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
	assign wByte   = wStrb_ff[0] ? wData_ff[7:0] : 8'h00;
	assign flagW1c = doWrite & (awAddr_ff == CCL_ADDR_CSR) & wStrb_ff[0]
		& wData_ff[CCL_S_FLAG];

	// Write address channel: accept one and hold it
	// Capture only on a real handshake; a valid seen while ready is low
	// would otherwise be taken a second time once the master sees ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_ff <= 1'b0;
		end
	end

	// Write data channel: accept one and hold it
	// Strobes are kept so a write with byte lane 0 off changes nothing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wHeld_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= '0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_ff <= 1'b0;
		end
	end

	// Ready reflects a free holding slot, registered for the output rule
	// Readies stay low while a reply waits, so no new write can overtake
	// a response the master has not yet accepted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~awHeld_ff & ~(s_axi_awvalid & s_axi_awready)
				& ~doWrite & ~bPending;
			s_axi_wready  <= ~wHeld_ff & ~(s_axi_wvalid & s_axi_wready)
				& ~doWrite & ~bPending;
		end
	end

	// Write response, unmapped addresses answer SLVERR
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bValid_ff <= 1'b0;
			bResp_ff  <= CCL_RESP_OKAY;
		end else if (doWrite) begin
			bValid_ff <= 1'b1;
			if (awAddr_ff == CCL_ADDR_CTRLB || awAddr_ff == CCL_ADDR_CSR
				|| awAddr_ff == CCL_ADDR_DIS || awAddr_ff == CCL_ADDR_CONV)
				bResp_ff <= CCL_RESP_OKAY;
			else
				bResp_ff <= CCL_RESP_SLVERR;
		end else if (bValid_ff & s_axi_bready) begin
			bValid_ff <= 1'b0;
		end
	end

	// Control register writes; the flag bit lives apart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlB_ff <= CCL_RST_B;
			csr_ff   <= CCL_RST_S;
			dis_ff   <= CCL_RST_D;
			conv_ff  <= CCL_RST_C;
		end else if (doWrite & wStrb_ff[0]) begin
			// [RULE14] masked control B
			if (awAddr_ff == CCL_ADDR_CTRLB) begin
				ctrlB_ff <= wByte & CCL_B_WMASK;
			// [RULE3] power-off writable anytime
			end else if (awAddr_ff == CCL_ADDR_CSR) begin
				csr_ff <= {wByte[7:6], 2'b00, wByte[3:0]};
			end else if (awAddr_ff == CCL_ADDR_DIS) begin
				dis_ff <= {6'h00, wByte[1:0]};
			end else if (awAddr_ff == CCL_ADDR_CONV) begin
				conv_ff <= wByte[3:0];
			end
		end
	end

	// Set has priority so an edge landing on the clearing cycle is kept
	// [RULE9] hw clears on vector, w1c; a same-cycle event wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			flag_ff <= 1'b0;
		else if (compFire)
			flag_ff <= 1'b1;
		else if (irq_vector_taken | flagW1c)
			flag_ff <= 1'b0;
	end

	// Read channel, one read at a time
	// The status byte splices in the live sync output and the flag, which
	// have no stored copy; unmapped reads return zero with SLVERR
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			rValid_ff     <= 1'b0;
			rData_ff      <= '0;
			rResp_ff      <= CCL_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			rValid_ff     <= 1'b1;
			rResp_ff      <= CCL_RESP_OKAY;
			if (s_axi_araddr == CCL_ADDR_CTRLB)
				rData_ff <= {24'h000000, ctrlB_ff};
			else if (s_axi_araddr == CCL_ADDR_CSR)
				rData_ff <= {24'h000000, csr_ff[7:6], compSync, flag_ff,
					csr_ff[3:0]};
			else if (s_axi_araddr == CCL_ADDR_DIS)
				rData_ff <= {24'h000000, dis_ff};
			else if (s_axi_araddr == CCL_ADDR_CONV)
				rData_ff <= {28'h0000000, conv_ff};
			else begin
				rData_ff <= '0;
				rResp_ff <= CCL_RESP_SLVERR;
			end
		end else if (rValid_ff) begin
			if (s_axi_rready)
				rValid_ff <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// Pin inputs come from outside, so two flops before use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			posPin1_ff <= 1'b0;
			posPin2_ff <= 1'b0;
			negPin1_ff <= 1'b0;
			negPin2_ff <= 1'b0;
		end else begin
			posPin1_ff <= comp_pos_pin_dig;
			posPin2_ff <= posPin1_ff;
			negPin1_ff <= comp_neg_pin_dig;
			negPin2_ff <= negPin1_ff;
		end
	end

	// The gate sits after the synchroniser, so a disable takes effect
	// one cycle after the register write lands
	// [RULE13] disabled buffer reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			posRead_ff <= 1'b0;
			negRead_ff <= 1'b0;
		end else begin
			posRead_ff <= posPin2_ff & ~dis_ff[CCL_D_POS];
			negRead_ff <= negPin2_ff & ~dis_ff[CCL_D_NEG];
		end
	end

	// Analog steering; registered so each output leaves a flop
	// Switching the converter on quietly returns the negative input to
	// its pin, even with the mux route bit still set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerOff_ff <= 1'b0;
			bgSel_ff    <= 1'b0;
			negRoute_ff <= 1'b0;
			negChan_ff  <= 3'b000;
		end else begin
			// [RULE3] power gate
			powerOff_ff <= csr_ff[CCL_S_PWROFF];
			// [RULE5] positive input select
			bgSel_ff    <= csr_ff[CCL_S_BGSEL];
			// [RULE1] [RULE2] negative input route
			negRoute_ff <= ctrlB_ff[CCL_B_MUXEN] & ~conv_ff[CCL_C_CONVON];
			// [RULE15] channel pick
			negChan_ff  <= neg_channel_select;
		end
	end

	// The vector pulse masks the request at once, so it does not linger
	// for a cycle after the flag has been cleared
	// [RULE8] irq gating; [RULE10] capture route
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_ff     <= 1'b0;
			capture_ff <= 1'b0;
		end else begin
			irq_ff     <= flag_ff & csr_ff[CCL_S_IRQEN] & cpu_global_irq_en
				& ~irq_vector_taken;
			// [RULE16] polarity passed through unchanged
			capture_ff <= csr_ff[CCL_S_CAPT] & compSync;
		end
	end

	assign s_axi_bvalid        = bValid_ff;
	assign s_axi_bresp         = bResp_ff;
	assign s_axi_rvalid        = rValid_ff;
	assign s_axi_rdata         = rData_ff;
	assign s_axi_rresp         = rResp_ff;
	assign comp_power_off      = powerOff_ff;
	assign comp_bandgap_select = bgSel_ff;
	assign neg_mux_route       = negRoute_ff;
	assign neg_channel_sel_out = negChan_ff;
	assign comp_irq            = irq_ff;
	assign capture_in          = capture_ff;
	assign pos_pin_buffer_off  = dis_ff[CCL_D_POS];
	assign neg_pin_buffer_off  = dis_ff[CCL_D_NEG];
	assign comp_pos_pin_read   = posRead_ff;
	assign comp_neg_pin_read   = negRead_ff;
endmodule

// ---- hdl/ccl_edge.sv ----
`timescale 1ns/1ps
// Edge detector on the synchronised comparator output
module ccl_edge
	import ccl_pkg::*;
(
	input  wire logic       clk,    // System clock
	input  wire logic       rst,    // Async reset, active high
	input  wire logic       level,  // Synchronised level
	input  wire logic [1:0] mode,   // Event mode field
	input  wire logic       block,  // Suppress events
	output logic            fire    // One-cycle event pulse
);
	logic prev_ff;

	// Previous sample of the level
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prev_ff <= 1'b0;
		else
			prev_ff <= level;
	end

	// [RULE17] compare with prior
	// [RULE18] reserved never fires
	assign fire = ~block & ccl_fire(mode, level, prev_ff);
endmodule

// ---- hdl/ccl_pkg.sv ----
package ccl_pkg;
	// Control B keeps its word index; the byte address is four times it
	localparam logic [7:0]  CCL_IDX_CTRLB   = 8'h7B;
	localparam logic [11:0] CCL_ADDR_CTRLB  = {2'b00, CCL_IDX_CTRLB, 2'b00};
	localparam logic [11:0] CCL_ADDR_CSR    = 12'h200;
	localparam logic [11:0] CCL_ADDR_DIS    = 12'h204;
	localparam logic [11:0] CCL_ADDR_CONV   = 12'h208;
	localparam int          CCL_AW          = 12;
	// Field positions in converter_control_b
	localparam int          CCL_B_MUXEN     = 6;
	localparam logic [7:0]  CCL_B_WMASK     = 8'h4F;
	// Field positions in comparator_control_status
	localparam int          CCL_S_PWROFF    = 7;
	localparam int          CCL_S_BGSEL     = 6;
	localparam int          CCL_S_OUT       = 5;
	localparam int          CCL_S_FLAG      = 4;
	localparam int          CCL_S_IRQEN     = 3;
	localparam int          CCL_S_CAPT      = 2;
	// Field positions in comparator_pin_input_disable
	localparam int          CCL_D_POS       = 0;
	localparam int          CCL_D_NEG       = 1;
	// Converter-side control word
	localparam int          CCL_C_CONVON    = 3;
	// Reset values
	localparam logic [7:0]  CCL_RST_B       = 8'h00;
	localparam logic [7:0]  CCL_RST_S       = 8'h00;
	localparam logic [7:0]  CCL_RST_D       = 8'h00;
	localparam logic [3:0]  CCL_RST_C       = 4'h0;
	// Event-mode encodings
	typedef enum logic [1:0] {
		CCL_EV_TOGGLE  = 2'b00,
		CCL_EV_RSVD    = 2'b01,
		CCL_EV_FALL    = 2'b10,
		CCL_EV_RISE    = 2'b11
	} ccl_evmode_t;
	// AXI responses
	localparam logic [1:0]  CCL_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  CCL_RESP_SLVERR = 2'b10;

	// Fire decision for an edge of the synchronized output
	// [RULE11] mode decode table
	function automatic logic ccl_fire(input logic [1:0] mode,
		input logic cur, input logic prev);
		logic f;
		f = 1'b0;
		case (mode)
			CCL_EV_TOGGLE: f = cur ^ prev;
			CCL_EV_FALL:   f = prev & ~cur;
			CCL_EV_RISE:   f = cur & ~prev;
			default:       f = 1'b0;
		endcase
		return f;
	endfunction
endpackage

// ---- hdl/ccl_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser with a synchronous hold-at-zero input
module ccl_sync (
	input  wire logic clk,     // System clock
	input  wire logic rst,     // Async reset, active high
	input  wire logic clear,   // Force output low (same domain)
	input  wire logic din,     // Asynchronous input
	output logic      dout     // Synchronised output
);
	logic stage1_ff;
	logic stage2_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
		end else begin
			stage1_ff <= din;
			stage2_ff <= clear ? 1'b0 : stage1_ff;
		end
	end

	assign dout = stage2_ff;
endmodule

// ---- tb/ccl_analog_model.sv ----
`timescale 1ns/1ps
// Behavioural comparator core working in millivolts
module ccl_analog_model (
	input wire logic       powerOff,   // Core powered down
	input wire logic       bandgapSel, // Positive from bandgap
	input wire logic       negMuxRoute,// Negative from channel
	input wire logic [2:0] negChannel, // Channel number
	input int              posPinMv,   // Positive pin level
	input int              negPinMv,   // Negative pin level
	input int              bandgapMv,  // Bandgap level
	input int              chanMv [8], // Channel levels
	output logic           rawOut      // Raw comparator output
);
	int posMv;
	int negMv;
	// Bandgap or pin on the positive side
	always_comb posMv = bandgapSel ? bandgapMv : posPinMv;
	// Channel or pin on the negative side
	always_comb negMv = negMuxRoute ? chanMv[negChannel] : negPinMv;
	// Unpowered core reads low, no stale level
	always_comb rawOut = !powerOff && (posMv > negMv);
endmodule

// ---- tb/ccl_checker.sv ----
`timescale 1ns/1ps
// Port-level properties of the comparator control block
module ccl_checker
	import ccl_pkg::*;
(
	input wire logic                    clk,          // Clock
	input wire logic                    rst,          // Reset
	input wire logic                    s_axi_awvalid,// AW valid
	input wire logic                    s_axi_awready,// AW ready
	input wire logic                    s_axi_wvalid, // W valid
	input wire logic                    s_axi_wready, // W ready
	input wire logic [1:0]              s_axi_bresp,  // B response
	input wire logic                    s_axi_bvalid, // B valid
	input wire logic                    s_axi_bready, // B ready
	input wire logic [ccl_pkg::CCL_AW-1:0] s_axi_araddr, // AR address
	input wire logic                    s_axi_arvalid,// AR valid
	input wire logic                    s_axi_arready,// AR ready
	input wire logic [31:0]             s_axi_rdata,  // R data
	input wire logic [1:0]              s_axi_rresp,  // R response
	input wire logic                    s_axi_rvalid, // R valid
	input wire logic                    s_axi_rready, // R ready
	input wire logic                    cpu_global_irq_en, // Global en
	input wire logic                    comp_irq,     // Irq request
	input wire logic [2:0]              neg_channel_select,  // Chan in
	input wire logic [2:0]              neg_channel_sel_out, // Chan out
	input wire logic                    pos_pin_buffer_off,  // Buf off
	input wire logic                    comp_pos_pin_read    // Pin read
);
	// One clock domain, so clocking and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Answers stand until the master accepts them
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	// Answer latency, ordering and content on the register bus; then irq, channel and pin checks
	write_answer_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("no write response");
	read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
		else $error("no read response");
	bus_order_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken while response pending");
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 12'h010 |=> s_axi_rresp == CCL_RESP_SLVERR)
		else $error("unmapped read not refused");
	upper_zero_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	irq_global_a: assert property (
		!cpu_global_irq_en |=> !comp_irq) else $error("irq without global");
	chan_copy_a: assert property (
		1'b1 |=> neg_channel_sel_out == $past(neg_channel_select))
		else $error("channel copy wrong");
	pin_gate_a: assert property (
		pos_pin_buffer_off [*3] |-> !comp_pos_pin_read)
		else $error("pin read while buffer off");
endmodule

bind ccl_comparator_ctrl ccl_checker chk (
	.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .cpu_global_irq_en(cpu_global_irq_en),
	.comp_irq(comp_irq), .neg_channel_select(neg_channel_select),
	.neg_channel_sel_out(neg_channel_sel_out),
	.pos_pin_buffer_off(pos_pin_buffer_off),
	.comp_pos_pin_read(comp_pos_pin_read)
);

// ---- tb/ccl_comparator_ctrl_tb.sv ----
`timescale 1ns/1ps
// Register-level bench for the comparator control block
module ccl_comparator_ctrl_tb;
	import ccl_pkg::*;
	logic        clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady, rawOut, globalEn;
	logic        vecTaken, posDig, negDig, pwrOff, bgSel, muxRoute, irq;
	logic        capIn, posBufOff, negBufOff, posRead, negRead;
	logic [11:0] awAddr, arAddr;
	logic [31:0] wData, rData, v;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, lastResp;
	logic [2:0]  chanSel, chanOut;
	int          posMv, negMv, bgMv, n_errors, cmp_count;
	int          chanMv [8];

	ccl_comparator_ctrl dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .comp_raw_out(rawOut),
		.cpu_global_irq_en(globalEn), .irq_vector_taken(vecTaken),
		.comp_pos_pin_dig(posDig), .comp_neg_pin_dig(negDig),
		.neg_channel_select(chanSel), .comp_power_off(pwrOff),
		.comp_bandgap_select(bgSel), .neg_mux_route(muxRoute),
		.neg_channel_sel_out(chanOut), .comp_irq(irq), .capture_in(capIn),
		.pos_pin_buffer_off(posBufOff), .neg_pin_buffer_off(negBufOff),
		.comp_pos_pin_read(posRead), .comp_neg_pin_read(negRead));
	ccl_analog_model core (.powerOff(pwrOff), .bandgapSel(bgSel),
		.negMuxRoute(muxRoute), .negChannel(chanOut), .posPinMv(posMv),
		.negPinMv(negMv), .bandgapMv(bgMv), .chanMv(chanMv), .rawOut(rawOut));

	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Ready is raised only once the answer shows, so the hold is exercised
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic aDone, dDone, hit;
		n = 0;
		aDone = 1'b0;
		dDone = 1'b0;
		awAddr <= a;
		wData <= {24'h000000, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			hit = bValid && bReady;
			if (!aDone && awReady) begin
				aDone = 1'b1;
				awValid <= 1'b0;
			end
			if (!dDone && wReady) begin
				dDone = 1'b1;
				wValid <= 1'b0;
			end
			if (bValid && !hit) bReady <= 1'b1;
		end while (!hit && n < 40);
		bReady <= 1'b0;
		lastResp = bResp;
		if (!hit) begin
			n_errors++;
			finish_test();
		end
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		logic aDone, hit;
		n = 0;
		aDone = 1'b0;
		arAddr <= a;
		arValid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			hit = rValid && rReady;
			if (!aDone && arReady) begin
				aDone = 1'b1;
				arValid <= 1'b0;
			end
			if (rValid && !hit) rReady <= 1'b1;
		end while (!hit && n < 40);
		rReady <= 1'b0;
		v = rData;
		lastResp = rResp;
		if (!hit) begin
			n_errors++;
			finish_test();
		end
		@(posedge clk);
	endtask

	initial begin
		{rst, wStrb} = 5'h1F;
		{awValid, wValid, bReady, arValid, rReady, globalEn} = 6'h00;
		{vecTaken, posDig, negDig, awAddr, arAddr, wData} = 0;
		{chanSel, n_errors, cmp_count, posMv} = 0;
		negMv = 500;
		bgMv = 700;
		for (int i = 0; i < 8; i++) chanMv[i] = i * 100;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(CCL_ADDR_CTRLB);
		chk(v, 32'h00000000);
		wr(CCL_ADDR_CTRLB, 8'hFF);
		rd(CCL_ADDR_CTRLB);
		chk(v, 32'h0000004F);
		chk(32'(muxRoute), 32'h1);
		wr(CCL_ADDR_CONV, 8'h08);
		chk(32'(muxRoute), 32'h0);
		wr(CCL_ADDR_CONV, 8'h00);
		// Channel k sits at k*100 mV against a 350 mV positive pin
		posMv <= 350;
		for (int i = 0; i < 8; i++) begin
			chanSel <= 3'(i);
			cyc(6);
			rd(CCL_ADDR_CSR);
			chk(32'(v[CCL_S_OUT]), 32'(350 > i * 100));
		end
		wr(CCL_ADDR_CTRLB, 8'h00);
		chk(32'(muxRoute), 32'h0);
		rd(12'h010);
		chk(32'(lastResp), 32'(CCL_RESP_SLVERR));
		wr(12'h010, 8'hFF);
		chk(32'(lastResp), 32'(CCL_RESP_SLVERR));
		wr(CCL_ADDR_CSR, 8'h40);
		chk(32'(bgSel), 32'h1);
		wr(CCL_ADDR_CSR, 8'h00);
		$display("test control and bus done");
		// Each event mode sees one rise and one fall
		for (int m = 0; m < 4; m++) begin
			posMv <= 0;
			cyc(6);
			wr(CCL_ADDR_CSR, 8'h10 | 8'(m));
			posMv <= 900;
			cyc(6);
			rd(CCL_ADDR_CSR);
			chk(32'(v[CCL_S_FLAG]), 32'(m == 0 || m == 3));
			chk(32'(v[CCL_S_OUT]), 32'h1);
			wr(CCL_ADDR_CSR, 8'h10 | 8'(m));
			posMv <= 0;
			cyc(6);
			rd(CCL_ADDR_CSR);
			chk(32'(v[CCL_S_FLAG]), 32'(m == 0 || m == 2));
		end
		$display("test event modes done");
		wr(CCL_ADDR_CSR, 8'h18);
		globalEn <= 1'b1;
		posMv <= 900;
		cyc(6);
		chk(32'(irq), 32'h1);
		globalEn <= 1'b0;
		cyc(3);
		chk(32'(irq), 32'h0);
		globalEn <= 1'b1;
		cyc(3);
		vecTaken <= 1'b1;
		@(posedge clk);
		vecTaken <= 1'b0;
		cyc(3);
		chk(32'(irq), 32'h0);
		rd(CCL_ADDR_CSR);
		chk(32'(v[CCL_S_FLAG]), 32'h0);
		$display("test interrupt done");
		wr(CCL_ADDR_CSR, 8'h14);
		cyc(4);
		chk(32'(capIn), 32'h1);
		posMv <= 0;
		cyc(6);
		chk(32'(capIn), 32'h0);
		wr(CCL_ADDR_CSR, 8'h10);
		posMv <= 900;
		cyc(6);
		chk(32'(capIn), 32'h0);
		wr(CCL_ADDR_CSR, 8'h93);
		chk(32'(pwrOff), 32'h1);
		posMv <= 0;
		cyc(6);
		posMv <= 900;
		cyc(6);
		rd(CCL_ADDR_CSR);
		chk(v, 32'h00000083);
		$display("test capture and power done");
		posDig <= 1'b1;
		negDig <= 1'b1;
		cyc(5);
		chk(32'(posRead & negRead), 32'h1);
		wr(CCL_ADDR_DIS, 8'h03);
		cyc(4);
		chk({30'h0, negRead, posRead}, 32'h0);
		chk({30'h0, negBufOff, posBufOff}, 32'h3);
		rd(CCL_ADDR_DIS);
		chk(v, 32'h00000003);
		$display("test pin buffers done");
		finish_test();
	end
endmodule
